// File: rtl/lane_link_status_bits.v
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

`include "lane_link_status_regs.vh"

// How it works
// R1: Disparity flag set when count reaches threshold
// R2: Table-miss flag set when count reaches threshold
// R3: Bad-control flag set when count reaches threshold
// R4: Bit 4 reports lane deskew success
// R5: Bit 3 reports alignment sequence sync
// R6: Bit 2 reports configuration checksum match
// R7: Bit 1 reports frame synchronization
// R8: Bit 0 reports code group synchronization
// R9: Software ignores bits 4..1 when skipping alignment
// R10: Flags from counters; status writes ignored
module lane_link_status_bits (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    output reg         irq_q,
    output reg         skip_align_sequence_q,
    input  wire        lane4_disparity_err,
    input  wire        lane4_table_miss,
    input  wire        lane4_bad_control_char,
    input  wire        lane4_deskew_ok,
    input  wire        lane4_align_seq_sync,
    input  wire        lane4_checksum_ok,
    input  wire        lane4_frame_sync,
    input  wire        lane4_code_group_sync,
    input  wire        lane3_align_seq_sync,
    input  wire        lane3_checksum_ok,
    input  wire        lane3_frame_sync,
    input  wire        lane3_code_group_sync
);

    // ======================================================
    // Address helpers
    // ======================================================
    function [15:0] byte_addr;
        input [11:0] idx;
        begin
            byte_addr = {2'b00, idx, 2'b00};
        end
    endfunction

    function hit;
        input [15:0] addr;
        input [11:0] idx;
        begin
            hit = (addr == byte_addr(idx));
        end
    endfunction

    // ======================================================
    // State
    // ======================================================
    reg  [7:0]  threshold_q;
    reg         clear_counts_q;
    reg  [3:0]  lane3_status_q;
    reg  [3:0]  irq_status_q;
    reg  [3:0]  irq_status_d;
    reg  [3:0]  irq_mask_q;
    reg  [3:0]  irq_mask_d;
    reg  [3:0]  irq_event;
    reg  [2:0]  l4_err_prev_q;
    reg         l4_cgs_prev_q;
    reg         l4_fs_prev_q;
    reg         l3_cgs_prev_q;
    reg  [31:0] rdata_d;
    reg         addr_ok;
    wire [7:0]  lane4_status;
    wire        access;
    wire        commit;
    wire        wr_commit;

    // ======================================================
    // Lane 4 status byte
    // ======================================================
    lane_status_byte u_lane4 (
        .pclk             (pclk),
        .presetn          (presetn),
        .threshold        (threshold_q),
        .clear_counts     (clear_counts_q),
        .disparity_err    (lane4_disparity_err),
        .table_miss       (lane4_table_miss),
        .bad_control_char (lane4_bad_control_char),
        .deskew_ok        (lane4_deskew_ok),
        .align_seq_sync   (lane4_align_seq_sync),
        .checksum_ok      (lane4_checksum_ok),
        .frame_sync       (lane4_frame_sync),
        .code_group_sync  (lane4_code_group_sync),
        .status_q         (lane4_status)
    );

    // ======================================================
    // Lane 3 low nibble
    // ======================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane3_status_q <= 4'h0;
        end else begin
            lane3_status_q[`ST_ALIGN_SEQ_SYNC]  <= lane3_align_seq_sync;  // see R5
            lane3_status_q[`ST_CHECKSUM_OK]     <= lane3_checksum_ok;     // see R6
            lane3_status_q[`ST_FRAME_SYNC]      <= lane3_frame_sync;      // see R7
            lane3_status_q[`ST_CODE_GROUP_SYNC] <= lane3_code_group_sync; // see R8
        end
    end

    // ======================================================
    // APB decode
    // ======================================================
    // One wait state: pready rises on the second access cycle,
    // which also keeps prdata straight from a flop.
    assign access    = psel && penable;
    assign commit    = access && pready_q;
    assign wr_commit = commit && pwrite && addr_ok;

    always @* begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        if (hit(paddr, `LANE3_STATUS_IDX)) begin
            rdata_d[3:0] = lane3_status_q;
        end else if (hit(paddr, `LANE4_STATUS_IDX)) begin
            rdata_d[7:0] = lane4_status;
        end else if (hit(paddr, `ERR_THRESHOLD_IDX)) begin
            rdata_d[7:0] = threshold_q;
        end else if (hit(paddr, `LINK_CTRL_IDX)) begin
            rdata_d[`CTRL_SKIP_ALIGN] = skip_align_sequence_q;
        end else if (hit(paddr, `IRQ_STATUS_IDX)) begin
            rdata_d[3:0] = irq_status_q;
        end else if (hit(paddr, `IRQ_MASK_IDX)) begin
            rdata_d[3:0] = irq_mask_q;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (access && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !addr_ok;
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
    end

    // ======================================================
    // Writable registers
    // ======================================================
    // Status bytes have no write path, so writes there are
    // accepted and dropped without an error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_q           <= `ERR_THRESHOLD_RESET;
            skip_align_sequence_q <= 1'b0;
            clear_counts_q        <= 1'b0;
        end else begin
            clear_counts_q <= 1'b0;
            if (wr_commit && hit(paddr, `ERR_THRESHOLD_IDX)) begin
                threshold_q <= pwdata[7:0];
            end
            if (wr_commit && hit(paddr, `LINK_CTRL_IDX)) begin
                skip_align_sequence_q <= pwdata[`CTRL_SKIP_ALIGN];
                clear_counts_q        <= pwdata[`CTRL_CLEAR_COUNTS];
            end
        end
    end

    // ======================================================
    // Interrupt events
    // ======================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l4_err_prev_q <= 3'h0;
            l4_cgs_prev_q <= 1'b0;
            l4_fs_prev_q  <= 1'b0;
            l3_cgs_prev_q <= 1'b0;
        end else begin
            l4_err_prev_q <= lane4_status[7:5];
            l4_cgs_prev_q <= lane4_status[`ST_CODE_GROUP_SYNC];
            l4_fs_prev_q  <= lane4_status[`ST_FRAME_SYNC];
            l3_cgs_prev_q <= lane3_status_q[`ST_CODE_GROUP_SYNC];
        end
    end

    // Error flags raise on rising edges, code group sync (both lanes) and lane 4 frame sync on loss.
    // Frame sync loss is meaningless while alignment is skipped.
    always @* begin
        irq_event = 4'h0;
        irq_event[`IRQ_L4_ERR_FLAG] =
            |(lane4_status[7:5] & ~l4_err_prev_q);
        irq_event[`IRQ_L4_CGS_LOST] =
            l4_cgs_prev_q && !lane4_status[`ST_CODE_GROUP_SYNC];
        irq_event[`IRQ_L4_FS_LOST] =
            l4_fs_prev_q && !lane4_status[`ST_FRAME_SYNC] &&
            !skip_align_sequence_q; // see R9
        irq_event[`IRQ_L3_CGS_LOST] =
            l3_cgs_prev_q && !lane3_status_q[`ST_CODE_GROUP_SYNC];
    end

    // A new event in the clearing cycle survives the clear
    always @* begin
        irq_status_d = irq_status_q;
        irq_mask_d   = irq_mask_q;
        if (wr_commit && hit(paddr, `IRQ_STATUS_IDX)) begin
            irq_status_d = irq_status_q & ~pwdata[3:0];
        end
        if (wr_commit && hit(paddr, `IRQ_MASK_IDX)) begin
            irq_mask_d = pwdata[3:0];
        end
        irq_status_d = irq_status_d | irq_event;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= 4'h0;
            irq_mask_q   <= `IRQ_MASK_RESET;
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_mask_q   <= irq_mask_d;
            irq_q        <= |(irq_status_d & irq_mask_d);
        end
    end

endmodule // lane_link_status_bits

// File: rtl/lane_link_status_regs.vh
`ifndef LANE_LINK_STATUS_REGS_VH
`define LANE_LINK_STATUS_REGS_VH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define LANE3_STATUS_IDX     12'h4B3
`define LANE4_STATUS_IDX     12'h4B4
`define ERR_THRESHOLD_IDX    12'h4C0
`define LINK_CTRL_IDX        12'h4C1
`define IRQ_STATUS_IDX       12'h4C2
`define IRQ_MASK_IDX         12'h4C3

// ==========================================================
// Lane status byte fields
// ==========================================================
`define ST_DISPARITY_ERR     7
`define ST_TABLE_MISS        6
`define ST_BAD_CTRL_CHAR     5
`define ST_DESKEW_OK         4
`define ST_ALIGN_SEQ_SYNC    3
`define ST_CHECKSUM_OK       2
`define ST_FRAME_SYNC        1
`define ST_CODE_GROUP_SYNC   0

// ==========================================================
// Control register fields
// ==========================================================
`define CTRL_SKIP_ALIGN      0
`define CTRL_CLEAR_COUNTS    1

// ==========================================================
// Interrupt status / mask fields
// ==========================================================
`define IRQ_L4_ERR_FLAG      0
`define IRQ_L4_CGS_LOST      1
`define IRQ_L4_FS_LOST       2
`define IRQ_L3_CGS_LOST      3
`define IRQ_WIDTH            4

// ==========================================================
// Reset values
// ==========================================================
`define LANE_STATUS_RESET    8'h00
`define ERR_THRESHOLD_RESET  8'hFF
`define LINK_CTRL_RESET      2'h0
`define IRQ_MASK_RESET       4'h0

`endif

// File: rtl/lane_status_byte.v
`timescale 1ns/1ps

`include "lane_link_status_regs.vh"

module lane_status_byte (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [7:0] threshold,
    input  wire       clear_counts,
    input  wire       disparity_err,
    input  wire       table_miss,
    input  wire       bad_control_char,
    input  wire       deskew_ok,
    input  wire       align_seq_sync,
    input  wire       checksum_ok,
    input  wire       frame_sync,
    input  wire       code_group_sync,
    output reg  [7:0] status_q
);

    // ======================================================
    // Saturating error counters
    // ======================================================
    reg  [7:0] disp_cnt_q;
    reg  [7:0] miss_cnt_q;
    reg  [7:0] ctrl_cnt_q;
    reg  [7:0] status_d;

    // Saturate rather than wrap so a flag cannot drop on overflow
    function [7:0] sat_inc;
        input [7:0] cnt;
        input       hit;
        begin
            if (hit && cnt != 8'hFF) begin
                sat_inc = cnt + 8'h01;
            end else begin
                sat_inc = cnt;
            end
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_cnt_q <= 8'h00;
            miss_cnt_q <= 8'h00;
            ctrl_cnt_q <= 8'h00;
        end else if (clear_counts) begin
            disp_cnt_q <= 8'h00;
            miss_cnt_q <= 8'h00;
            ctrl_cnt_q <= 8'h00;
        end else begin
            disp_cnt_q <= sat_inc(disp_cnt_q, disparity_err);
            miss_cnt_q <= sat_inc(miss_cnt_q, table_miss);
            ctrl_cnt_q <= sat_inc(ctrl_cnt_q, bad_control_char);
        end
    end

    // ======================================================
    // Status byte assembly
    // ======================================================
    always @* begin
        status_d = `LANE_STATUS_RESET;
        status_d[`ST_DISPARITY_ERR]   = disp_cnt_q >= threshold; // see R1
        status_d[`ST_TABLE_MISS]      = miss_cnt_q >= threshold; // see R2
        status_d[`ST_BAD_CTRL_CHAR]   = ctrl_cnt_q >= threshold; // see R3
        status_d[`ST_DESKEW_OK]       = deskew_ok;               // see R4
        status_d[`ST_ALIGN_SEQ_SYNC]  = align_seq_sync;          // see R5
        status_d[`ST_CHECKSUM_OK]     = checksum_ok;             // see R6
        status_d[`ST_FRAME_SYNC]      = frame_sync;              // see R7
        status_d[`ST_CODE_GROUP_SYNC] = code_group_sync;         // see R8
    end

    // Registered so the flags lag the counters by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `LANE_STATUS_RESET;
        end else begin
            status_q <= status_d; // see R10
        end
    end

endmodule // lane_status_byte

// File: verification/lane_link_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side receiver logic: sync levels and error pulses
// ==========================================================
module lane_link_partner (
    input  logic       pclk,
    input  logic       presetn,
    input  logic [8:0] level_set,
    input  logic [2:0] err_fire,
    output logic [8:0] levels_q,
    output logic [2:0] errs_q
);
    // Registered so every change lands just after an edge, like the
    // link state machines that feed the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            levels_q <= 9'h000;
            errs_q   <= 3'h0;
        end else begin
            levels_q <= level_set;
            errs_q   <= err_fire;
        end
    end
endmodule // lane_link_partner

// File: verification/lane_link_status_bits_asserts.sv
`timescale 1ns/1ps
module lane_link_status_bits_asserts (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [15:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata_q,
    input logic        pready_q,
    input logic        pslverr_q,
    input logic        irq_q,
    input logic        skip_align_sequence_q,
    input logic        lane4_deskew_ok,
    input logic        lane4_align_seq_sync,
    input logic        lane4_checksum_ok,
    input logic        lane4_frame_sync,
    input logic        lane4_code_group_sync,
    input logic        lane3_align_seq_sync,
    input logic        lane3_checksum_ok,
    input logic        lane3_frame_sync,
    input logic        lane3_code_group_sync
);
    wire [4:0] l4 = {lane4_deskew_ok, lane4_align_seq_sync,
                     lane4_checksum_ok, lane4_frame_sync,
                     lane4_code_group_sync};
    wire [3:0] l3 = {lane3_align_seq_sync, lane3_checksum_ok,
                     lane3_frame_sync, lane3_code_group_sync};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; !pready_q ##1 pready_q; endsequence
    sequence rd_s(a); pready_q && !pwrite && paddr == a; endsequence
    chk_ready_late: assert property (setup_s |=> answer_s)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("pready longer than one cycle");
    chk_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0)
        else $error("read data outside answer");
    chk_unmapped_err: assert property (pready_q && paddr < 16'h12CC
        |-> pslverr_q && prdata_q == 32'h0) else $error("no slave error");
    chk_status_noerr: assert property (
        pready_q && (paddr == 16'h12D0 || paddr == 16'h12CC)
        |-> !pslverr_q) else $error("status error");
    // Levels must have been steady long enough to pass both registers
    chk_lane4_levels: assert property (
        rd_s(16'h12D0) and ($past(l4, 1) == l4 && $past(l4, 2) == l4
        && $past(l4, 3) == l4) |-> prdata_q[4:0] == l4)
        else $error("lane4 levels");
    chk_lane3_levels: assert property (
        rd_s(16'h12CC) and ($past(l3, 1) == l3 && $past(l3, 2) == l3
        && $past(l3, 3) == l3) |-> prdata_q == {28'h0, l3})
        else $error("lane3 levels");
    chk_mask_quiet: assert property (pready_q && pwrite && paddr ==
        16'h130C && pwdata[3:0] == 4'h0 |-> ##2 !irq_q)
        else $error("irq with empty mask");
    chk_skip_ctrl: assert property (pready_q && pwrite && paddr ==
        16'h1304 |=> skip_align_sequence_q == $past(pwdata[0]))
        else $error("skip bit not written");
endmodule // lane_link_status_bits_asserts

// File: verification/test_lane_link_status_bits.sv
`timescale 1ns/1ps
module test_lane_link_status_bits;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata_q, rd_v;
    logic        pready_q, pslverr_q, irq_q, skip_align_sequence_q, err_v;
    logic [8:0]  level_set = 9'h000, lv;
    logic [2:0]  err_fire = 3'h0, ev;
    int          miscompares = 0, checked = 0, cycles = 0;
    always #25 pclk = ~pclk;
    lane_link_partner far_u (.pclk(pclk), .presetn(presetn),
        .level_set(level_set), .err_fire(err_fire), .levels_q(lv),
        .errs_q(ev));
    lane_link_status_bits dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .irq_q(irq_q),
        .skip_align_sequence_q(skip_align_sequence_q),
        .lane4_disparity_err(ev[2]), .lane4_table_miss(ev[1]),
        .lane4_bad_control_char(ev[0]), .lane4_deskew_ok(lv[8]),
        .lane4_align_seq_sync(lv[7]), .lane4_checksum_ok(lv[6]),
        .lane4_frame_sync(lv[5]), .lane4_code_group_sync(lv[4]),
        .lane3_align_seq_sync(lv[3]), .lane3_checksum_ok(lv[2]),
        .lane3_frame_sync(lv[1]), .lane3_code_group_sync(lv[0]));
    // ==========================================================
    // Bus and check tasks
    // ==========================================================
    task close_out;
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready_q !== 1'b1) @(posedge pclk);
        rd_v = prdata_q;
        err_v = pslverr_q;
        psel <= 0; penable <= 0;
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e, input logic s);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rd_v);
        chk("slave error", {31'h0, s}, {31'h0, err_v});
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", 32'h0, {31'h0, err_v});
    endtask
    task settle; repeat (4) @(posedge pclk); endtask
    task pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge pclk); err_fire <= m;
            @(posedge pclk); err_fire <= 3'h0;
        end
        settle;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rd(16'h12CC, 32'h0, 0);
        rd(16'h12D0, 32'h0, 0);
        rd(16'h1300, 32'hFF, 0);
        rd(16'h130C, 32'h0, 0);
        rd(16'h1000, 32'h0, 1);
        for (int b = 0; b < 9; b++) begin
            level_set <= 9'h001 << b;
            settle;
            if (b < 4) rd(16'h12CC, 32'h1 << b, 0);
            else rd(16'h12D0, 32'h1 << (b - 4), 0);
        end
        level_set <= 9'h1F0;
        settle;
        wr(16'h12D0, 32'h0);
        rd(16'h12D0, 32'h1F, 0);
        // Threshold 3: two errors stay below, the third reaches it
        wr(16'h1300, 32'h3);
        for (int k = 0; k < 3; k++) begin
            wr(16'h1304, 32'h2);
            pulse(3'h1 << k, 2);
            rd(16'h12D0, 32'h1F, 0);
            pulse(3'h1 << k, 1);
            rd(16'h12D0, 32'h1F | (32'h20 << k), 0);
        end
        chk("irq", 32'h0, {31'h0, irq_q});
        rd(16'h1308, 32'hF, 0);
        wr(16'h130C, 32'h2);
        settle;
        chk("irq", 32'h1, {31'h0, irq_q});
        wr(16'h1308, 32'h2);
        settle;
        chk("irq", 32'h0, {31'h0, irq_q});
        rd(16'h1308, 32'hD, 0);
        wr(16'h130C, 32'h0);
        wr(16'h1308, 32'hF);
        rd(16'h1308, 32'h0, 0);
        wr(16'h1304, 32'h1);
        @(posedge pclk);
        chk("skip", 32'h1, {31'h0, skip_align_sequence_q});
        // Frame sync drops while alignment is skipped: no event
        level_set <= 9'h1D0;
        settle;
        rd(16'h1308, 32'h0, 0);
        rd(16'h12D0, 32'h9D, 0);
        wr(16'h1304, 32'h0);
        close_out;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out;
        end
    end
endmodule // test_lane_link_status_bits
bind lane_link_status_bits lane_link_status_bits_asserts chk_u (.*);
